// ### hw/spp_port.sv
// serial peripheral port: master/slave byte exchange behind AXI4-Lite registers
// assumes pin inputs are asynchronous; the bench resolves pin levels from enables
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module spp_port
	import spp_pkg::*;
#(
	parameter bit HAS_WIRE_OR = 1'b1
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sckIn,
	input  wire logic        mosiIn,
	input  wire logic        misoIn,
	input  wire logic        selectInN,
	output spp_pins_t        pinOut,
	output logic             portIrq
);
	spp_ctrl_t  ctrl_reg;
	spp_state_t state_reg;
	logic [3:0] inMeta_reg;
	logic [3:0] inSync_reg;
	logic       sckPrev_reg;
	logic [7:0] shift_reg;
	logic [7:0] rxBuf_reg;
	logic       outBit_reg;
	logic       sckLevel_reg;
	logic [3:0] edgeCnt_reg;
	logic [2:0] bitCnt_reg;
	logic       doneFlag_reg;
	logic       wcolFlag_reg;
	logic       modfFlag_reg;
	logic       statArmed_reg;
	logic       awHeld_reg;
	logic       wHeld_reg;
	logic [7:0] awAddr_reg;
	logic [7:0] wData_reg;
	logic       wLane0_reg;
	logic [5:0] late_reg;
	logic [7:0] mRx_reg;
	spp_pins_t  pinNext;

	////////////////////////////////////////////////////////////////////////////
	// synchronised pins
	logic syncSck;
	logic syncMosi;
	logic syncMiso;
	logic syncSelN;
	assign syncSck  = inSync_reg[3];
	assign syncMosi = inSync_reg[2];
	assign syncMiso = inSync_reg[1];
	assign syncSelN = inSync_reg[0];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			inMeta_reg  <= SYNC_RESET;
			inSync_reg  <= SYNC_RESET;
			sckPrev_reg <= 1'b0;
		end else begin
			inMeta_reg  <= {sckIn, mosiIn, misoIn, selectInN};
			inSync_reg  <= inMeta_reg;
			sckPrev_reg <= syncSck;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode decode
	logic isMaster;
	logic isSlave;
	logic slaveSel;
	logic modeFault;
	logic masterRun;
	assign isMaster  = ctrl_reg.sysEn && ctrl_reg.masterSel;
	assign isSlave   = ctrl_reg.sysEn && !ctrl_reg.masterSel;
	assign slaveSel  = isSlave && !syncSelN;
	assign modeFault = isMaster && !syncSelN;
	assign masterRun = (state_reg == ST_MASTER) && isMaster;

	////////////////////////////////////////////////////////////////////////////
	// register bus decode
	logic       doWrite;
	logic       wrCtrl;
	logic       wrData;
	logic       wrHit;
	logic       rdTake;
	logic       rdCtrl;
	logic       rdStat;
	logic       rdData;
	logic [7:0] rdByte;
	logic [7:0] statByte;
	assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign wrHit   = (awAddr_reg == CTRL_ADDR) || (awAddr_reg == STAT_ADDR)
	                 || (awAddr_reg == DATA_ADDR);
	assign wrCtrl  = doWrite && wLane0_reg && (awAddr_reg == CTRL_ADDR);
	assign wrData  = doWrite && wLane0_reg && (awAddr_reg == DATA_ADDR);
	assign rdTake  = s_axi_arvalid && s_axi_arready;
	assign rdCtrl  = s_axi_araddr == CTRL_ADDR;
	assign rdStat  = s_axi_araddr == STAT_ADDR;
	assign rdData  = s_axi_araddr == DATA_ADDR;
	assign statByte = (8'(doneFlag_reg) << STAT_DONE_BIT)
	                | (8'(wcolFlag_reg) << STAT_WRITE_COLLISION_FLAG_BIT)
	                | (8'(modfFlag_reg) << STAT_MODE_FAULT_FLAG_BIT);
	assign rdByte  = rdCtrl ? ctrl_reg :
	                 rdStat ? statByte :
	                 rdData ? rxBuf_reg : 8'h00;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg  <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg  <= 8'h00;
			wLane0_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg  <= 1'b1;
				wData_reg  <= s_axi_wdata[7:0];
				wLane0_reg <= s_axi_wstrb[0];
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rdTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rdByte};
			s_axi_rresp  <= (rdCtrl || rdStat || rdData) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shift clock edges
	logic tick;
	logic mLead;
	logic mTrail;
	logic sRise;
	logic sFall;
	logic sLead;
	logic sTrail;
	logic leadEdge;
	logic trailEdge;
	logic sampleEdge;
	logic launchEdge;
	logic rxIn;
	logic xferDone;
	logic clkEnd;
	logic busy;
	logic loadOk;

	spp_rate_div #(
		.CNT_W (5)
	) u_rate_div (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.run     (masterRun),
		.rate    (ctrl_reg.rate),
		.tick    (tick)
	);

	assign mLead  = masterRun && tick && !edgeCnt_reg[0];
	assign mTrail = masterRun && tick && edgeCnt_reg[0];
	assign sRise  = syncSck && !sckPrev_reg;
	assign sFall  = !syncSck && sckPrev_reg;
	// slave shifts only while selected; rate bits play no part here
	assign sLead  = slaveSel && (ctrl_reg.clock_polarity ? sFall : sRise);
	assign sTrail = slaveSel && (ctrl_reg.clock_polarity ? sRise : sFall);
	assign leadEdge   = mLead || sLead;
	assign trailEdge  = mTrail || sTrail;
	assign sampleEdge = ctrl_reg.clock_phase ? trailEdge : leadEdge;
	assign launchEdge = ctrl_reg.clock_phase ? leadEdge : trailEdge;
	assign rxIn = isMaster ? syncMiso : syncMosi;
	assign clkEnd   = mTrail && edgeCnt_reg == LAST_EDGE;
	// master sees its own miso three clocks late: output flop and two sync flops
	assign xferDone = isMaster ? late_reg[5]
	                : (sampleEdge && bitCnt_reg == LAST_BIT);
	assign busy   = masterRun || late_reg != 6'h00 || (slaveSel && bitCnt_reg != 3'h0);
	assign loadOk = wrData && !busy;

	////////////////////////////////////////////////////////////////////////////
	// transfer engine
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
		end else if (!isMaster || modeFault) begin
			state_reg <= ST_IDLE;
		end else if (loadOk) begin
			state_reg <= ST_MASTER;
		end else if (clkEnd) begin
			state_reg <= ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			edgeCnt_reg  <= 4'h0;
			sckLevel_reg <= 1'b0;
		end else if (!masterRun) begin
			edgeCnt_reg  <= 4'h0;
			sckLevel_reg <= ctrl_reg.clock_polarity;
		end else if (tick) begin
			edgeCnt_reg  <= edgeCnt_reg + 4'h1;
			sckLevel_reg <= !sckLevel_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			shift_reg  <= DATA_RESET;
			outBit_reg <= 1'b0;
			bitCnt_reg <= 3'h0;
		end else if (loadOk) begin
			shift_reg  <= wData_reg;
			outBit_reg <= wData_reg[7];
			bitCnt_reg <= 3'h0;
		end else if (isSlave && syncSelN && !ctrl_reg.clock_phase) begin
			bitCnt_reg <= 3'h0;
			outBit_reg <= shift_reg[7];
		end else begin
			if (sampleEdge) begin
				shift_reg  <= {shift_reg[6:0], rxIn};
				bitCnt_reg <= bitCnt_reg + 3'h1;
			end
			if (launchEdge) begin
				outBit_reg <= shift_reg[7];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive buffer and flags
	logic clrArm;
	logic dataAccess;
	logic clrDone;
	logic clrModf;
	logic overrun;
	logic [7:0] rxByte;
	assign dataAccess = wrData || (rdTake && rdData);
	assign clrDone = statArmed_reg && dataAccess;
	assign clrModf = statArmed_reg && wrCtrl;
	assign clrArm  = dataAccess || wrCtrl;
	assign overrun = doneFlag_reg && !clrDone;
	assign rxByte  = !isMaster ? {shift_reg[6:0], rxIn} :
	                 late_reg[4] ? {mRx_reg[6:0], syncMiso} : mRx_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rxBuf_reg <= DATA_RESET;
		end else if (xferDone && !overrun) begin
			rxBuf_reg <= rxByte;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			statArmed_reg <= 1'b0;
		end else if (rdTake && rdStat) begin
			statArmed_reg <= 1'b1;
		end else if (clrArm) begin
			statArmed_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			doneFlag_reg <= 1'b0;
			wcolFlag_reg <= 1'b0;
			modfFlag_reg <= 1'b0;
		end else begin
			doneFlag_reg <= xferDone || (doneFlag_reg && !clrDone);
			wcolFlag_reg <= (wrData && busy)
			                || (wcolFlag_reg && !clrDone);
			modfFlag_reg <= modeFault || (modfFlag_reg && !clrModf);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= CTRL_RESET;
		end else if (modeFault) begin
			ctrl_reg.sysEn     <= 1'b0;
			ctrl_reg.masterSel <= 1'b0;
		end else if (wrCtrl) begin
			ctrl_reg        <= wData_reg;
			ctrl_reg.wireOr <= HAS_WIRE_OR && wData_reg[CTRL_WIRE_OR_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drive and interrupt
	always_comb begin
		pinNext = '0;
		if (isMaster) begin
			pinNext.sckO   = masterRun ? sckLevel_reg : ctrl_reg.clock_polarity;
			pinNext.sckOe  = 1'b1;
			pinNext.mosiO  = outBit_reg;
			pinNext.mosiOe = 1'b1;
		end else if (slaveSel) begin
			pinNext.misoO  = outBit_reg;
			pinNext.misoOe = 1'b1;
		end
		if (ctrl_reg.wireOr) begin
			pinNext.sckOe  = pinNext.sckOe && !pinNext.sckO;
			pinNext.mosiOe = pinNext.mosiOe && !pinNext.mosiO;
			pinNext.misoOe = pinNext.misoOe && !pinNext.misoO;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinOut   <= '0;
			portIrq  <= 1'b0;
			late_reg <= 6'h00;
			mRx_reg  <= DATA_RESET;
		end else begin
			pinOut   <= pinNext;
			portIrq  <= doneFlag_reg && ctrl_reg.irqEn;
			late_reg <= {late_reg[3:0], clkEnd, masterRun && sampleEdge};
			mRx_reg  <= late_reg[4] ? {mRx_reg[6:0], syncMiso} : mRx_reg;
		end
	end

endmodule // spp_port

// ### hw/spp_pkg.sv
// package of the serial peripheral port: register map, field positions, types
// assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock
package spp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register indices and byte addresses
	localparam logic [7:0] CTRL_IDX  = 8'h0A;
	localparam logic [7:0] STAT_IDX  = 8'h0B;
	localparam logic [7:0] DATA_IDX  = 8'h0C;
	localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'h0};
	localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'h0};
	localparam logic [7:0] DATA_ADDR = {DATA_IDX[5:0], 2'h0};

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_IRQ_EN_BIT = 7;
	localparam int CTRL_SYS_EN_BIT = 6;
	localparam int CTRL_WIRE_OR_BIT = 5;
	localparam int CTRL_MASTER_BIT = 4;
	localparam int CTRL_CLOCK_POLARITY_BIT = 3;
	localparam int CTRL_CLOCK_PHASE_BIT = 2;
	localparam int CTRL_RATE_HI_BIT = 1;
	localparam int CTRL_RATE_LO_BIT = 0;
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
	localparam int STAT_MODE_FAULT_FLAG_BIT = 4;

	////////////////////////////////////////////////////////////////////////////
	// reset values and counts
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [3:0] SYNC_RESET = 4'h1;
	localparam logic [4:0] HALF_DIV2  = 5'h01;
	localparam logic [4:0] HALF_DIV4  = 5'h02;
	localparam logic [4:0] HALF_DIV16 = 5'h08;
	localparam logic [4:0] HALF_DIV32 = 5'h10;
	localparam logic [2:0] LAST_BIT   = 3'h7;
	localparam logic [3:0] LAST_EDGE  = 4'hF;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic       irqEn;
		logic       sysEn;
		logic       wireOr;
		logic       masterSel;
		logic       clock_polarity;
		logic       clock_phase;
		logic [1:0] rate;
	} spp_ctrl_t;

	typedef struct packed {
		logic sckO;
		logic sckOe;
		logic mosiO;
		logic mosiOe;
		logic misoO;
		logic misoOe;
	} spp_pins_t;

	typedef enum {ST_IDLE, ST_MASTER} spp_state_t;

endpackage

// ### hw/spp_rate_div.sv
// shift clock rate divider: one-cycle tick per half period of the shift clock
// assumes run is low between transfers so each transfer starts a fresh count
`timescale 1ns/10ps
module spp_rate_div
	import spp_pkg::*;
#(
	parameter int CNT_W = 5
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             run,
	input  wire logic [1:0]       rate,
	output logic                  tick
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] halfCnt;
	logic             wrap;

	////////////////////////////////////////////////////////////////////////////
	// divisors 2, 4, 16, 32 for codes 00..11
	assign halfCnt = (rate == 2'h0) ? CNT_W'(HALF_DIV2) :
	                 (rate == 2'h1) ? CNT_W'(HALF_DIV4) :
	                 (rate == 2'h2) ? CNT_W'(HALF_DIV16) : CNT_W'(HALF_DIV32);
	assign wrap = run && (cnt_reg == halfCnt - CNT_W'(1));
	assign tick = wrap;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (!run || wrap) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + CNT_W'(1);
		end
	end

endmodule // spp_rate_div

// ### bench/spp_assertions.sv
// checker of the serial port: bus handshakes, shift clock pacing, interrupt mask
// assumes full-byte writes; the control value is tracked from completed bus writes
`timescale 1ns/10ps
module spp_assertions
	import spp_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire spp_pins_t   pinOut,
	input wire logic        portIrq
);
	logic [7:0] awa_reg;
	logic [7:0] wd_reg;
	spp_ctrl_t  ctl_reg;
	logic       bv_reg;
	logic       mst_reg;
	////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awa_reg <= 8'h00;
			wd_reg <= 8'h00;
			ctl_reg <= spp_ctrl_t'(8'h00);
			bv_reg <= 1'b0;
			mst_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) awa_reg <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wd_reg <= s_axi_wdata[7:0];
			if (s_axi_bvalid && !bv_reg && awa_reg == CTRL_ADDR) ctl_reg <= spp_ctrl_t'(wd_reg);
			bv_reg <= s_axi_bvalid;
			mst_reg <= ctl_reg.sysEn && ctl_reg.masterSel;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_rdata_hi;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	property p_irq_mask;
		!ctl_reg.irqEn |-> !portIrq;
	endproperty
	property p_rate;
		$changed(pinOut.sckO) && ctl_reg.sysEn && ctl_reg.masterSel && ctl_reg.rate[1]
			|=> $stable(pinOut.sckO) [*7];
	endproperty
	property p_slave_quiet;
		!(ctl_reg.sysEn && ctl_reg.masterSel) && !mst_reg |-> !pinOut.sckOe && !pinOut.mosiOe;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	a_rhold: assert property (p_rhold) else $error("read response dropped early");
	a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
	a_w_block: assert property (p_w_block) else $error("write taken while busy");
	a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
	a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
	a_rate: assert property (p_rate) else $error("shift clock too fast");
	a_slave_quiet: assert property (p_slave_quiet) else $error("clock driven off master");
	c_irq: cover property ($rose(portIrq));
	c_slow: cover property ($changed(pinOut.sckO) && ctl_reg.rate == 2'h3);
	c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // spp_assertions

// ### bench/spp_far_model.sv
// far serial device acting as slave of the port's master
// assumes arm rises before the first clock edge of each byte
`timescale 1ns/10ps
module spp_far_model (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       clock_polarity,
	input  wire logic       clock_phase,
	input  wire logic       arm,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic [7:0]      rx
);
	int n = 8;
	initial miso = 1'b0;
	initial rx = 8'h00;
	always @(posedge arm) begin
		n = 0;
		rx = 8'h00;
		miso = clock_phase ? ~miso : tx[7];
	end
	always @(sck) begin
		if (n < 8 && sck !== clock_polarity) begin
			if (clock_phase) miso = tx[7 - n];
			else rx = {rx[6:0], mosi};
		end else if (n < 8) begin
			if (clock_phase) rx = {rx[6:0], mosi};
			n = n + 1;
			miso = (!clock_phase && n < 8) ? tx[7 - n] : ~miso;
		end
	end
endmodule // spp_far_model

// ### bench/testbench.sv
// self-checking bench of the serial port: bus tasks, far slave, pin monitor
// assumes pull-ups on sck and mosi (miso falls back to the far slave) and full-byte bus writes
`timescale 1ns/10ps
module testbench
	import spp_pkg::*;
;
	logic        sys_clk, nrst, awValid, wValid, bReady, arValid, rReady, selectInN, farArm;
	logic        awReady, wReady, bValid, arReady, rValid, portIrq, farMiso, sckPrev;
	logic [7:0]  awAddr, arAddr, farTx, farRx, seed, c, d, s;
	logic [31:0] wData, rData, rd;
	logic [1:0]  bResp, rResp, br, rr;
	spp_pins_t   pinOut;
	int          fail_count, compares, edgeCnt, cyc, lastEdge, half;
	wire         sckW = pinOut.sckOe ? pinOut.sckO : 1'b1;
	wire         mosiW = pinOut.mosiOe ? pinOut.mosiO : 1'b1;
	wire         misoW = pinOut.misoOe ? pinOut.misoO : farMiso;
	spp_port dut_u (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .sckIn(sckW),
		.mosiIn(mosiW), .misoIn(misoW), .selectInN(selectInN), .pinOut(pinOut),
		.portIrq(portIrq));
	spp_far_model far_u (.sck(sckW), .mosi(mosiW), .clock_polarity(c[3]), .clock_phase(c[2]), .arm(farArm),
		.tx(farTx), .miso(farMiso), .rx(farRx));
	////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic int halfOf(input logic [1:0] r);
		return r == 2'h0 ? 1 : r == 2'h1 ? 2 : r == 2'h2 ? 8 : 16;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
		logic da, dw, bv, tb;
		da = 0;
		dw = 0;
		tb = 0;
		@(posedge sys_clk);
		awAddr <= a;
		wData <= {24'h0, v};
		awValid <= 1'b1;
		wValid <= 1'b1;
		while (!tb) begin
			@(negedge sys_clk);
			if (awValid & awReady) da = 1;
			if (wValid & wReady) dw = 1;
			bv = bValid;
			tb = bv & bReady;
			r = bResp;
			@(posedge sys_clk);
			if (da) awValid <= 1'b0;
			if (dw) wValid <= 1'b0;
			bReady <= bv & !tb;
		end
	endtask
	task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic ta, rv, tr;
		tr = 0;
		@(posedge sys_clk);
		arAddr <= a;
		arValid <= 1'b1;
		while (!tr) begin
			@(negedge sys_clk);
			ta = arValid & arReady;
			rv = rValid;
			tr = rv & rReady;
			v = rData;
			r = rResp;
			@(posedge sys_clk);
			if (ta) arValid <= 1'b0;
			rReady <= rv & !tr;
		end
	endtask
	task automatic xfer(input logic [7:0] cc, input logic [7:0] dd, input logic [7:0] ss,
		input bit coll);
		axiWrite(CTRL_ADDR, cc, br);
		c <= cc;
		repeat (4) @(posedge sys_clk);
		chk(pinOut.sckOe, cc[5] ? !cc[3] : 1'b1);
		farTx <= ss;
		farArm <= 1'b1;
		edgeCnt = 0;
		half = halfOf(cc[1:0]);
		axiWrite(DATA_ADDR, dd, br);
		if (coll) axiWrite(DATA_ADDR, ~dd, br);
		while (edgeCnt < 16) @(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		farArm <= 1'b0;
	endtask
	task automatic chkXfer(input logic [7:0] cc, input logic [7:0] dd, input logic [7:0] ss,
		input logic [7:0] st);
		chk(farRx, dd);
		chk(sckW, cc[3]);
		chk(portIrq, cc[7]);
		axiRead(STAT_ADDR, rd, rr);
		chk(rd, st);
		axiRead(DATA_ADDR, rd, rr);
		chk(rd, ss);
		axiRead(STAT_ADDR, rd, rr);
		chk(rd, 32'h0);
		chk(portIrq, 1'b0);
	endtask
	////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		cyc++;
		if (sckW !== sckPrev) begin
			if (edgeCnt > 0 && edgeCnt < 16) chk(cyc - lastEdge, half);
			lastEdge = cyc;
			edgeCnt++;
		end
		sckPrev = sckW;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		close_out();
	end
	initial begin
		{nrst, awValid, wValid, bReady, arValid, rReady, farArm} = 7'h00;
		{awAddr, arAddr, farTx, wData, c} = '0;
		selectInN = 1'b1;
		sckPrev = 1'b1;
		seed = 8'h2C;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			axiRead(CTRL_ADDR + 8'(4 * k), rd, rr);
			chk(rd, 32'h0);
		end
		axiRead(8'h00, rd, rr);
		chk(rr, RESP_SLVERR);
		axiWrite(8'h00, 8'h5A, br);
		chk(br, RESP_SLVERR);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			d = seed;
			seed = lfsr(seed);
			s = seed;
			xfer({seed[0], 1'b1, seed[1], 1'b1, seed[2], i[2:0]}, d, s, 0);
			chkXfer(c, d, s, 8'h80);
		end
		xfer(8'hD0, 8'h5A, 8'hC3, 0);
		xfer(8'hD0, 8'h96, 8'h3E, 0);
		chkXfer(8'hD0, 8'h96, 8'hC3, 8'h80);
		xfer(8'h53, 8'hA7, 8'h19, 1);
		chkXfer(8'h53, 8'hA7, 8'h19, 8'hC0);
		for (int k = 0; k < 2; k++) begin
			axiWrite(CTRL_ADDR, k ? 8'h13 : 8'h43, br);
			repeat (4) @(posedge sys_clk);
			edgeCnt = 0;
			axiWrite(DATA_ADDR, 8'h3C, br);
			repeat (300) @(posedge sys_clk);
			chk(edgeCnt, 0);
			chk(pinOut.misoOe, 1'b0);
			axiRead(STAT_ADDR, rd, rr);
			chk(rd, 32'h0);
		end
		edgeCnt = 16;
		axiWrite(CTRL_ADDR, 8'h50, br);
		selectInN <= 1'b0;
		repeat (8) @(posedge sys_clk);
		selectInN <= 1'b1;
		axiRead(STAT_ADDR, rd, rr);
		chk(rd, 32'h10);
		axiWrite(CTRL_ADDR, 8'h00, br);
		axiRead(STAT_ADDR, rd, rr);
		chk(rd, 32'h0);
		close_out();
	end
endmodule // testbench
bind spp_port spp_assertions chk_u (.sys_clk(sys_clk), .nrst(nrst),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pinOut(pinOut), .portIrq(portIrq));
